//--- src/pir_scan_map.svh
// Offsets, field positions, reset values and timing counts of the scan controller
`ifndef PIR_SCAN_MAP_SVH
`define PIR_SCAN_MAP_SVH

// Register indices (printed offsets are not word multiples; byte address = 4 * index)
`define IDX_LIGHT_THRESHOLD_AND_RANGE 12'h104
`define IDX_AUX_CHANNEL_SCAN_REQUEST  12'h105
`define IDX_SCAN_CONTROL              12'h103
`define IDX_CONVERSION_RESULT         12'h10a
`define IDX_ENGINE_STATUS             12'h102

// Field positions
`define SCAN_RATE_BIT     2
`define DUAL_SENSOR_BIT   0
`define MOTION_BIT        1
`define SUPPRESS_BIT      2
`define RANGE_LSB         0
`define THRESH_LSB        3
`define REQ_RESERVED_MASK 8'h08

// Reset values
`define LIGHT_RANGE_RESET 8'h00
`define SCAN_CONTROL_RESET 8'h00

// Timing
`define NORMAL_PERIOD_CYC 256
`define LOW_CONV_CYC      5129
`define SUPPRESS_MS       200
`define CLK_HZ            25000000

`endif

//--- src/pir_scan_pkg.sv
// Types shared by the scan controller files
package pir_scan_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SENSOR = 3'b001,
    ST_LIGHT  = 3'b010,
    ST_AUX    = 3'b011,
    ST_WAIT   = 3'b100
  } conv_state_t;

  typedef enum logic [1:0] {
    SRC_SENSOR_A = 2'b00,
    SRC_SENSOR_B = 2'b01,
    SRC_LIGHT    = 2'b10,
    SRC_AUX      = 2'b11
  } conv_src_t;
endpackage

//--- src/low_priority_pick.sv
// Picks the lowest set bit of a request vector
`timescale 1ns/1ps
module low_priority_pick #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0]         req_in,
  output logic                          any_out,
  output logic [$clog2(WIDTH)-1:0]      idx_out
);
  // Scan from the top so the lowest index wins
  always_comb begin
    any_out = 1'b0;
    idx_out = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (req_in[i]) begin
        any_out = 1'b1;
        idx_out = i[$clog2(WIDTH)-1:0];
      end
    end
  end
endmodule

//--- src/pir_scan_ctrl.sv
// Scan-rate pacing, sensor selection and auxiliary conversion arbitration
//
// Notes on behaviour
// - Each finished sensor conversion raises service event.
// - Scan rate bit: 0 normal, 1 low.
// - Normal rate: auto conversion every 256 cycles.
// - Low rate: single shot, 5129 cycles each.
// - Converter powered off between low-rate conversions.
// - Interference immunity off in low rate.
// - Rate change suppresses detection up to 200 ms.
// - Dual bit: channel 2 only, or add 3.
// - Dual mode samples both; either motion detects.
// - Threshold zero disables light detection.
// - Light uses buffered single-ended channel 1.
// - Low power ignores threshold, light off.
// - Three-bit range; larger means shorter range.
// - Request: unbuffered, 2 V, sample, store, clear.
// - Pin configuration stays after request served.
// - Several requests: lowest wins, rest discarded.
// - Sensor conversions paused during request service.
// - Request bit reads 1 while pending.
// - Channel 1 reserved while light detection on.
// - Result register changes only on request completion.
// - Engine sets motion flag; software clears it.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "pir_scan_map.svh"
module pir_scan_ctrl #(
  parameter int CHANNELS       = 8,
  parameter int SUPPRESS_CYC   = (`SUPPRESS_MS * (`CLK_HZ / 1000)),
  parameter int LOW_PERIOD_CYC = 125000
) (
  input  wire logic                     mclk_in,
  input  wire logic                     rst_in,
  // APB slave
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [15:0]              paddr_in,
  input  wire logic [31:0]              pwdata_in,
  output logic [31:0]                   prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  // Converter side
  input  wire logic                     conv_done_in,
  input  wire logic [15:0]              conv_data_in,
  input  wire logic                     sw_start_in,
  input  wire logic                     low_power_in,
  input  wire logic                     motion_a_in,
  input  wire logic                     motion_b_in,
  output logic                          conv_start_out,
  output logic                          conv_continuous_out,
  output logic                          conv_power_out,
  output logic [2:0]                    conv_channel_out,
  output logic                          conv_buffered_out,
  output logic                          conv_ref_2v_out,
  output logic                          service_event_out,
  output logic                          emi_immunity_out,
  output logic                          detect_enable_out,
  output logic                          light_detect_on_out,
  output logic [4:0]                    light_threshold_out,
  output logic [2:0]                    range_out,
  output logic [7:0]                    pin_analog_cfg_out
);
  import pir_scan_pkg::*;

  localparam logic [12:0] LOW_CONV = 13'(`LOW_CONV_CYC);
  localparam logic [8:0]  NORM_PER = 9'(`NORMAL_PERIOD_CYC);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  light_range;
    logic [7:0]  scan_request;
    logic        scan_rate;
    logic        dual_sensor;
    logic        motion;
    logic [15:0] result;
    logic [7:0]  pin_cfg;
    conv_state_t state;
    conv_src_t   src;
    logic [2:0]  aux_ch;
    logic [8:0]  pace;
    logic [12:0] conv_cnt;
    logic [31:0] suppress_cnt;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        start;
    logic        power;
    logic [2:0]  channel;
    logic        buffered;
    logic        ref_2v;
    logic        service;
    logic        light_next;
  } ctrl_state_t;

  ctrl_state_t cur;
  ctrl_state_t next_cur;

  logic              req_any;
  logic [2:0]        req_idx;
  logic [7:0]        req_eligible;
  logic              light_on;
  logic              low_rate;
  logic              access;
  logic [13:0]       word_idx;
  logic              rate_change;

  // Lowest-numbered pending request wins
  low_priority_pick #(.WIDTH(CHANNELS)) pick (
    .req_in  (req_eligible),
    .any_out (req_any),
    .idx_out (req_idx)
  );

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  assign low_rate     = cur.scan_rate;
  assign light_on     = (cur.light_range[7:`THRESH_LSB] != 5'h00) && !low_power_in;
  assign req_eligible = cur.scan_request & ~(light_on ? 8'h02 : 8'h00);
  assign access       = psel_in && penable_in;
  assign word_idx     = paddr_in[15:2];

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_cur         = cur;
    next_cur.pready  = 1'b0;
    next_cur.pslverr = 1'b0;
    next_cur.start   = 1'b0;
    next_cur.service = 1'b0;
    rate_change      = 1'b0;

    // Bus access: single-cycle answer once the access phase opens
    if (access && !cur.pready) begin
      next_cur.pready = 1'b1;
      next_cur.prdata = 32'h0000_0000;
      case (word_idx[11:0])
        `IDX_LIGHT_THRESHOLD_AND_RANGE: begin
          if (pwrite_in) next_cur.light_range = pwdata_in[7:0];
          next_cur.prdata = {24'h000000, cur.light_range};
        end
        `IDX_AUX_CHANNEL_SCAN_REQUEST: begin
          // Writes only add requests; engine alone clears them
          if (pwrite_in) next_cur.scan_request = cur.scan_request | (pwdata_in[7:0] & ~`REQ_RESERVED_MASK);
          next_cur.prdata = {24'h000000, cur.scan_request};
        end
        `IDX_SCAN_CONTROL: begin
          if (pwrite_in) begin
            rate_change          = pwdata_in[`SCAN_RATE_BIT] != cur.scan_rate;
            next_cur.scan_rate   = pwdata_in[`SCAN_RATE_BIT];
            next_cur.dual_sensor = pwdata_in[`DUAL_SENSOR_BIT];
          end
          next_cur.prdata = {29'h0, cur.scan_rate, 1'b0, cur.dual_sensor};
        end
        `IDX_ENGINE_STATUS: begin
          // Writing one clears the motion flag
          if (pwrite_in && pwdata_in[`MOTION_BIT]) next_cur.motion = 1'b0;
          next_cur.prdata = {29'h0, (cur.suppress_cnt != 32'h0), cur.motion, 1'b0};
        end
        `IDX_CONVERSION_RESULT: begin
          next_cur.prdata = {16'h0000, cur.result};
        end
        default: begin
          next_cur.pslverr = 1'b1;
        end
      endcase
    end

    // Rate change holds off detection for a while
    if (rate_change) next_cur.suppress_cnt = 32'(SUPPRESS_CYC);
    else if (cur.suppress_cnt != 32'h0) next_cur.suppress_cnt = cur.suppress_cnt - 32'h1;

    // Pace counter for normal-rate automatic conversions
    if (!low_rate) begin
      if (cur.pace == NORM_PER - 9'h1) next_cur.pace = 9'h000;
      else next_cur.pace = cur.pace + 9'h1;
    end else begin
      next_cur.pace = 9'h000;
    end

    // Conversion sequencer
    case (cur.state)
      ST_IDLE: begin
        next_cur.power = !low_rate;
        if (req_any) begin
          // Serve request; sensor scans paused meanwhile
          next_cur.state    = ST_AUX;
          next_cur.aux_ch   = req_idx;
          next_cur.channel  = req_idx;
          next_cur.buffered = 1'b0;
          next_cur.ref_2v   = 1'b1;
          next_cur.power    = 1'b1;
          next_cur.start    = 1'b1;
          next_cur.pin_cfg  = cur.pin_cfg | (8'h01 << req_idx);
          next_cur.conv_cnt = LOW_CONV;
        end else if ((!low_rate && cur.pace == NORM_PER - 9'h1) || (low_rate && sw_start_in)) begin
          next_cur.state    = ST_SENSOR;
          next_cur.src      = SRC_SENSOR_A;
          next_cur.channel  = 3'd2;
          next_cur.buffered = 1'b0;
          next_cur.ref_2v   = 1'b0;
          next_cur.power    = 1'b1;
          next_cur.start    = 1'b1;
          next_cur.conv_cnt = low_rate ? LOW_CONV : 13'h0000;
        end
      end
      ST_SENSOR: begin
        if (low_rate && cur.conv_cnt != 13'h0000) next_cur.conv_cnt = cur.conv_cnt - 13'h1;
        if (conv_done_in && (!low_rate || cur.conv_cnt == 13'h0000)) begin
          next_cur.service = 1'b1;
          if (cur.src == SRC_SENSOR_A && cur.dual_sensor) begin
            // Second sensor in the same scan
            next_cur.src      = SRC_SENSOR_B;
            next_cur.channel  = 3'd3;
            next_cur.start    = 1'b1;
            next_cur.conv_cnt = low_rate ? LOW_CONV : 13'h0000;
          end else if (light_on) begin
            next_cur.state    = ST_LIGHT;
            next_cur.src      = SRC_LIGHT;
            next_cur.channel  = 3'd1;
            next_cur.buffered = 1'b1;
            next_cur.start    = 1'b1;
          end else begin
            next_cur.state = ST_WAIT;
          end
        end
      end
      ST_LIGHT: begin
        if (conv_done_in) begin
          next_cur.service = 1'b1;
          next_cur.state   = ST_WAIT;
        end
      end
      ST_AUX: begin
        if (conv_done_in) begin
          next_cur.result       = conv_data_in;
          next_cur.scan_request = 8'h00;
          next_cur.state        = ST_WAIT;
        end
      end
      ST_WAIT: begin
        next_cur.state = ST_IDLE;
        next_cur.power = !low_rate;
      end
      default: begin
        next_cur.state = ST_IDLE;
      end
    endcase

    // Motion from sensor A, or B in dual mode, unless held off; set beats clear
    if (cur.suppress_cnt == 32'h0 && (motion_a_in || (cur.dual_sensor && motion_b_in)))
      next_cur.motion = 1'b1;

    next_cur.light_next = light_on;
  end

  // ------------------------------------------------------------
  // Register stage
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cur              <= '0;
      cur.light_range  <= `LIGHT_RANGE_RESET;
      cur.state        <= ST_IDLE;
      cur.src          <= SRC_SENSOR_A;
      cur.channel      <= 3'd2;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from flops
  assign prdata_out          = cur.prdata;
  assign pready_out          = cur.pready;
  assign pslverr_out         = cur.pslverr;
  assign conv_start_out      = cur.start;
  assign conv_continuous_out = !cur.scan_rate;
  assign conv_power_out      = cur.power;
  assign conv_channel_out    = cur.channel;
  assign conv_buffered_out   = cur.buffered;
  assign conv_ref_2v_out     = cur.ref_2v;
  assign service_event_out   = cur.service;
  assign emi_immunity_out    = !cur.scan_rate;
  assign detect_enable_out   = !cur.motion;
  assign light_detect_on_out = cur.light_next;
  assign light_threshold_out = cur.light_range[7:`THRESH_LSB];
  assign range_out           = cur.light_range[2:`RANGE_LSB];
  assign pin_analog_cfg_out  = cur.pin_cfg;
endmodule

//--- test/pir_scan_ctrl_props.sv
// Port-level assertions for the scan controller
`timescale 1ns/1ps
module pir_scan_ctrl_props (
  input wire logic       mclk_in,
  input wire logic       rst_in,
  input wire logic       sw_start_in,
  input wire logic       low_power_in,
  input wire logic       motion_a_in,
  input wire logic       motion_b_in,
  input wire logic       conv_done_in,
  input wire logic       conv_start_out,
  input wire logic       conv_continuous_out,
  input wire logic       conv_power_out,
  input wire logic [2:0] conv_channel_out,
  input wire logic       conv_buffered_out,
  input wire logic       conv_ref_2v_out,
  input wire logic       service_event_out,
  input wire logic       emi_immunity_out,
  input wire logic       detect_enable_out,
  input wire logic       light_detect_on_out,
  input wire logic [4:0] light_threshold_out,
  input wire logic [7:0] pin_analog_cfg_out
);
  // ----------------------------------------
  // Helper logic and properties
  // ----------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic [8:0] gap;   // Cycles since last normal-rate sensor start
  logic       armed; // Cleared in low rate so a mode change never fakes a gap
  always_ff @(posedge mclk_in) begin
    if (rst_in || !conv_continuous_out) begin
      gap   <= 9'h000;
      armed <= 1'b0;
    end else if (conv_start_out && conv_channel_out == 3'h2) begin
      gap   <= 9'h000;
      armed <= 1'b1;
    end else if (gap != 9'h1ff) begin
      gap <= gap + 9'h001;
    end
  end
  // Light detection must be held off by either cause
  sequence light_cut;
    (low_power_in || light_threshold_out == 5'h00) [*2];
  endsequence
  a_normal_gap: assert property (armed && conv_start_out && conv_channel_out == 3'h2 |-> gap >= 9'h0ff)
    else $error("Sensor start came early");
  a_low_sw_start: assert property (conv_start_out && conv_channel_out == 3'h2 && !conv_continuous_out
    |-> $past(sw_start_in) || $past(sw_start_in, 2)) else $error("Low-rate start without software");
  a_low_emi_off: assert property (!conv_continuous_out |-> !emi_immunity_out)
    else $error("Immunity active in low rate");
  a_low_power_off: assert property (!conv_continuous_out && service_event_out |-> ##[1:4] !conv_power_out)
    else $error("Converter left powered");
  a_aux_pin_cfg: assert property (conv_start_out && (conv_channel_out == 3'h0 || conv_channel_out >= 3'h4)
    |-> !conv_buffered_out && conv_ref_2v_out) else $error("Aux channel set up wrongly");
  a_light_held_off: assert property (light_cut |-> !light_detect_on_out)
    else $error("Light detection not off");
  a_pin_cfg_sticky: assert property (!$past(rst_in) |-> ($past(pin_analog_cfg_out) & ~pin_analog_cfg_out) == 8'h00)
    else $error("Pin setup restored");
  a_motion_cause: assert property ($fell(detect_enable_out)
    |-> $past(motion_a_in || motion_b_in) || $past(motion_a_in || motion_b_in, 2)) else $error("Motion flag uncaused");
  a_done_event: assert property (conv_done_in && conv_continuous_out && conv_channel_out == 3'h2
    |-> ##[1:2] service_event_out) else $error("Conversion not serviced");
endmodule

bind pir_scan_ctrl pir_scan_ctrl_props pir_scan_ctrl_props_inst (.mclk_in, .rst_in, .sw_start_in, .low_power_in,
  .motion_a_in, .motion_b_in, .conv_done_in, .conv_start_out, .conv_continuous_out, .conv_power_out,
  .conv_channel_out, .conv_buffered_out, .conv_ref_2v_out, .service_event_out, .emi_immunity_out,
  .detect_enable_out, .light_detect_on_out, .light_threshold_out, .pin_analog_cfg_out);

//--- test/adc_model.sv
// Behavioural converter answering the scan controller
`timescale 1ns/1ps
module adc_model (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        start_in,
  input  wire logic        continuous_in,
  input  wire logic [2:0]  channel_in,
  input  wire logic [12:0] lat_in,
  output logic             done_out,
  output logic [15:0]      data_out
);
  logic [12:0] cnt;
  logic [2:0]  ch;
  // Data toggles outside done so stale values never pass as a result
  always_ff @(posedge mclk_in) begin
    done_out <= 1'b0;
    data_out <= ~data_out;
    if (rst_in) begin
      cnt      <= 13'h0000;
      data_out <= 16'h0000;
    end else if (start_in) begin
      cnt <= continuous_in ? lat_in : 13'h1409;
      ch  <= channel_in;
    end else if (cnt == 13'h0001) begin
      cnt      <= 13'h0000;
      done_out <= 1'b1;
      data_out <= {13'h0c5a, ch};
    end else if (cnt != 13'h0000) begin
      cnt <= cnt - 13'h0001;
    end
  end
endmodule

//--- test/pir_scan_ctrl_tb_top.sv
// Self-checking bench for the scan controller over APB
`timescale 1ns/1ps
`include "pir_scan_map.svh"
module pir_scan_ctrl_tb_top;
  localparam logic [15:0] A_ST = 16'(4 * `IDX_ENGINE_STATUS);
  localparam logic [15:0] A_SC = 16'(4 * `IDX_SCAN_CONTROL);
  localparam logic [15:0] A_LR = 16'(4 * `IDX_LIGHT_THRESHOLD_AND_RANGE);
  localparam logic [15:0] A_RQ = 16'(4 * `IDX_AUX_CHANNEL_SCAN_REQUEST);
  localparam logic [15:0] A_RS = 16'(4 * `IDX_CONVERSION_RESULT);
  logic        mclk_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, er;
  logic        conv_done_in, sw_start_in, low_power_in, motion_a_in, motion_b_in, conv_start_out;
  logic        conv_continuous_out, conv_power_out, conv_buffered_out, conv_ref_2v_out, service_event_out;
  logic        emi_immunity_out, detect_enable_out, light_detect_on_out;
  logic [2:0]  conv_channel_out, range_out;
  logic [4:0]  light_threshold_out;
  logic [7:0]  pin_analog_cfg_out;
  logic [12:0] lat;
  logic [15:0] paddr_in, conv_data_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  int          failures, cmp_count, n;

  pir_scan_ctrl #(.SUPPRESS_CYC(50)) pir_scan_ctrl_inst (.mclk_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .conv_done_in, .conv_data_in, .sw_start_in,
    .low_power_in, .motion_a_in, .motion_b_in, .conv_start_out, .conv_continuous_out, .conv_power_out,
    .conv_channel_out, .conv_buffered_out, .conv_ref_2v_out, .service_event_out, .emi_immunity_out,
    .detect_enable_out, .light_detect_on_out, .light_threshold_out, .range_out, .pin_analog_cfg_out);
  adc_model adc_model_inst (.mclk_in, .rst_in, .start_in(conv_start_out), .continuous_in(conv_continuous_out),
    .channel_in(conv_channel_out), .lat_in(lat), .done_out(conv_done_in), .data_out(conv_data_in));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk_in);
  endtask
  // One APB transfer; ends one edge after release so strobes never double-assign
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel_in   <= 1'b1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge mclk_in) penable_in <= 1'b1;
    do begin @(posedge mclk_in); k++; end while (pready_out !== 1'b1 && k < 50);
    rd = prdata_out;
    er = pslverr_out;
    if (k >= 50) failures++;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  // Poll the request register until served, as software would
  task automatic poll;
    int k;
    k = 0;
    do begin apb(1'b0, A_RQ, 32'h0); k++; end while (rd !== 32'h0 && k < 200);
  endtask
  task automatic wait_ch2;
    n = 0;
    do begin @(posedge mclk_in); n++; end while (!(conv_start_out === 1'b1 && conv_channel_out === 3'h2) && n < 9000);
  endtask
  task automatic report_and_stop;
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  initial begin
    #2000000;
    failures++;
    report_and_stop;
  end
  initial begin
    {rst_in, psel_in, penable_in, pwrite_in, sw_start_in, low_power_in, motion_a_in, motion_b_in} = 8'h80;
    paddr_in  = 16'h0000;
    pwdata_in = 32'h0;
    lat       = 13'h000a;
    failures  = 0;
    cmp_count = 0;
    tick(6);
    rst_in <= 1'b0;
    tick(1);
    chk({conv_channel_out, conv_continuous_out, emi_immunity_out, detect_enable_out, conv_power_out}, 7'h2e);
    apb(1'b0, A_SC, 32'h0);
    chk(rd, `SCAN_CONTROL_RESET);
    apb(1'b0, 16'h0000, 32'h0);
    chk(er, 1'b1);
    wait_ch2();
    wait_ch2();
    chk(n, 256);
    apb(1'b1, A_LR, 32'hd5);
    apb(1'b0, A_LR, 32'h0);
    chk(rd, 32'hd5);
    chk({light_threshold_out, range_out, light_detect_on_out}, 9'h1ab);
    low_power_in <= 1'b1;
    tick(3);
    chk(light_detect_on_out, 1'b0);
    low_power_in <= 1'b0;
    apb(1'b1, A_LR, 32'h0);
    tick(2);
    chk(light_detect_on_out, 1'b0);
    // Slow converter so the pending state is visible
    lat = 13'h0064;
    apb(1'b1, A_RQ, 32'hf8);
    apb(1'b0, A_RQ, 32'h0);
    chk(rd, 32'hf0);
    poll();
    chk(rd, 32'h0);
    apb(1'b0, A_RS, 32'h0);
    chk(rd, 32'h62d4);
    chk(pin_analog_cfg_out, 8'h10);
    apb(1'b1, A_LR, 32'h08);
    apb(1'b1, A_RQ, 32'h02);
    tick(300);
    apb(1'b0, A_RQ, 32'h0);
    chk(rd, 32'h02);
    apb(1'b0, A_RS, 32'h0);
    chk(rd, 32'h62d4);
    apb(1'b1, A_LR, 32'h0);
    poll();
    apb(1'b0, A_RS, 32'h0);
    chk(rd, 32'h62d1);
    chk(pin_analog_cfg_out, 8'h12);
    lat = 13'h000a;
    // Tuning registers live outside this block, so nothing to load first
    apb(1'b1, A_SC, 32'h04);
    tick(2);
    chk({conv_continuous_out, emi_immunity_out}, 2'h0);
    apb(1'b0, A_ST, 32'h0);
    chk(rd[2], 1'b1);
    tick(300);
    chk(conv_power_out, 1'b0);
    sw_start_in <= 1'b1;
    tick(1);
    sw_start_in <= 1'b0;
    n = 0;
    do begin @(posedge mclk_in); n++; end while (service_event_out !== 1'b1 && n < 6000);
    chk(n >= 5129 && n < 5200, 1'b1);
    tick(5);
    chk(conv_power_out, 1'b0);
    apb(1'b0, A_ST, 32'h0);
    chk(rd[2], 1'b0);
    apb(1'b1, A_SC, 32'h01);
    tick(60);
    motion_b_in <= 1'b1;
    tick(1);
    motion_b_in <= 1'b0;
    tick(3);
    chk(detect_enable_out, 1'b0);
    apb(1'b0, A_ST, 32'h0);
    chk(rd[1], 1'b1);
    apb(1'b1, A_ST, 32'h02);
    tick(2);
    chk(detect_enable_out, 1'b1);
    report_and_stop;
  end
endmodule
